// ### hw/twrq_regs.v
// test word and requantizer control register slice, top level
`timescale 1ns/10ps
`include "twrq_consts.vh"

// Contract
// [RULE_01] word b low nibble in bits 7:4
// [RULE_02] software keeps word b bits 3:0 zero
// [RULE_03] word b bits 11:4 fill 0x77
// [RULE_04] word a bits 11:4 fill its register
// [RULE_05] clear bit toggle resets both requantizers; code clears a only in single/dual mode, b only in dual mode
// [RULE_06] setting change resets that requantizer
// [RULE_07] channel a setting, bits 6:0, resets zero
// [RULE_08] dual mode applies setting a to a
// [RULE_09] 0x78 acts in single/dual modes only
// [RULE_10] bit 7 enables dual post-processing
// [RULE_11] channel b setting, bits 6:0, resets zero
// [RULE_12] dual mode applies setting b to b
// [RULE_13] test word shown only when selected
module twrq_regs (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [`TWRQ_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [`TWRQ_DATA_W-1:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [`TWRQ_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output wire [`TWRQ_DATA_W-1:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // converter operating mode
  input wire single_ch_mode,
  input wire dual_ch_mode,
  // test pattern inputs
  input wire [2:0] output_test_select,
  input wire [3:0] test_word_a_nibble,
  // test pattern outputs
  output reg [11:0] test_data,
  output reg test_data_active,
  output reg [3:0] unused_test_pins,
  // requantizer controls
  output wire [6:0] requant_ch_a_setting,
  output wire [6:0] requant_ch_b_setting,
  output wire requant_state_clear_a,
  output wire requant_state_clear_b,
  // post-processing
  output reg dual_postproc_enable
);

  // register storage
  reg [7:0] test_word_a_high;
  reg [7:0] test_word_b_low;
  reg [7:0] test_word_b_high;
  reg [7:0] requant_clear_ch_a_cfg;
  reg [7:0] dual_postproc_ch_b_cfg;

  // previous value of the clear bit
  reg clear_bit_prev;

  // bus side wires
  wire wr_fire;
  wire [`TWRQ_IDX_W-1:0] wr_idx;
  wire [7:0] wr_byte;
  wire wr_lane0;
  wire wr_hit;
  wire [`TWRQ_IDX_W-1:0] rd_idx;
  reg [7:0] rd_byte;
  wire rd_hit;
  wire [2:0] wr_sel;
  wire [2:0] rd_sel;
  wire wr_go;

  // per channel wires
  wire [6:0] ch_setting [0:1];
  wire [1:0] ch_enable;
  wire [1:0] ch_clear;
  wire [13:0] ch_applied;
  wire clear_bit;
  wire clear_toggle;
  wire mode_ok;

  // assembled test words
  wire [11:0] word_a;
  wire [11:0] word_b;

  // index to select code
  function [2:0] reg_sel;
    input [`TWRQ_IDX_W-1:0] idx;
    begin
      case (idx)
        `TWRQ_IDX_A_HIGH: reg_sel = `TWRQ_SEL_A_HIGH;
        `TWRQ_IDX_B_LOW: reg_sel = `TWRQ_SEL_B_LOW;
        `TWRQ_IDX_B_HIGH: reg_sel = `TWRQ_SEL_B_HIGH;
        `TWRQ_IDX_CLR_A: reg_sel = `TWRQ_SEL_CLR_A;
        `TWRQ_IDX_POST_B: reg_sel = `TWRQ_SEL_POST_B;
        default: reg_sel = `TWRQ_SEL_NONE;
      endcase
    end
  endfunction

  // upper byte and lower nibble to one test word
  function [11:0] join_word;
    input [7:0] upper_byte;
    input [3:0] lower_nib;
    begin
      join_word = {upper_byte, lower_nib};
    end
  endfunction

  twrq_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_fire(wr_fire),
    .wr_idx(wr_idx),
    .wr_byte(wr_byte),
    .wr_lane0(wr_lane0),
    .wr_hit(wr_hit),
    .rd_idx(rd_idx),
    .rd_byte(rd_byte),
    .rd_hit(rd_hit)
  );

  // address decode
  assign wr_sel = reg_sel(wr_idx);
  assign rd_sel = reg_sel(rd_idx);
  assign wr_hit = (wr_sel != `TWRQ_SEL_NONE);
  assign rd_hit = (rd_sel != `TWRQ_SEL_NONE);
  assign wr_go = wr_fire & wr_lane0;

  // register writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      test_word_a_high <= `TWRQ_RST_BYTE;
      test_word_b_low <= `TWRQ_RST_BYTE;
      test_word_b_high <= `TWRQ_RST_BYTE;
      requant_clear_ch_a_cfg <= `TWRQ_RST_BYTE; // [RULE_07]
      dual_postproc_ch_b_cfg <= `TWRQ_RST_BYTE; // [RULE_11]
    end else if (wr_go) begin
      case (wr_sel)
        `TWRQ_SEL_A_HIGH: begin
          test_word_a_high <= wr_byte; // [RULE_04]
        end
        `TWRQ_SEL_B_LOW: begin
          test_word_b_low <= wr_byte; // [RULE_01]
        end
        `TWRQ_SEL_B_HIGH: begin
          test_word_b_high <= wr_byte; // [RULE_03]
        end
        `TWRQ_SEL_CLR_A: begin
          requant_clear_ch_a_cfg <= wr_byte; // [RULE_07]
        end
        `TWRQ_SEL_POST_B: begin
          dual_postproc_ch_b_cfg <= wr_byte; // [RULE_10]
        end
        default: begin
          test_word_a_high <= test_word_a_high;
        end
      endcase
    end
  end

  // register reads
  always @* begin
    case (rd_sel)
      `TWRQ_SEL_A_HIGH: rd_byte = test_word_a_high;
      `TWRQ_SEL_B_LOW: rd_byte = test_word_b_low;
      `TWRQ_SEL_B_HIGH: rd_byte = test_word_b_high;
      `TWRQ_SEL_CLR_A: rd_byte = requant_clear_ch_a_cfg;
      `TWRQ_SEL_POST_B: rd_byte = dual_postproc_ch_b_cfg;
      default: rd_byte = `TWRQ_RST_BYTE;
    endcase
  end

  // clear bit edge in either direction
  always @(posedge aclk) begin
    if (!aresetn) begin
      clear_bit_prev <= 1'b0;
    end else begin
      clear_bit_prev <= clear_bit;
    end
  end

  assign clear_bit = requant_clear_ch_a_cfg[`TWRQ_CLR_BIT];
  assign clear_toggle = clear_bit ^ clear_bit_prev; // [RULE_05]
  assign mode_ok = single_ch_mode | dual_ch_mode; // [RULE_09]

  // channel settings and where each applies
  assign ch_setting[0] = requant_clear_ch_a_cfg[`TWRQ_SET_MSB:0];
  assign ch_setting[1] = dual_postproc_ch_b_cfg[`TWRQ_SET_MSB:0];
  assign ch_enable[0] = mode_ok; // [RULE_08] [RULE_09]
  assign ch_enable[1] = dual_ch_mode; // [RULE_12]

  // per channel apply and state clear
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      reg [6:0] applied;
      reg clear_pulse;
      wire [6:0] next_applied;
      wire toggle_hit;
      wire set_change;
      assign next_applied = ch_enable[ch] ? ch_setting[ch] : `TWRQ_RST_SET;
      assign toggle_hit = ch_enable[ch] & clear_toggle; // [RULE_05]
      assign set_change = (next_applied != applied); // [RULE_06]
      always @(posedge aclk) begin
        if (!aresetn) begin
          applied <= `TWRQ_RST_SET;
          clear_pulse <= 1'b0;
        end else begin
          applied <= next_applied;
          clear_pulse <= toggle_hit | set_change; // [RULE_05] [RULE_06]
        end
      end
      assign ch_applied[ch*7 +: 7] = applied;
      assign ch_clear[ch] = clear_pulse;
    end
  endgenerate

  assign requant_ch_a_setting = ch_applied[6:0];
  assign requant_ch_b_setting = ch_applied[13:7];
  assign requant_state_clear_a = ch_clear[0];
  assign requant_state_clear_b = ch_clear[1];

  // word assembly from upper byte and lower nibble
  assign word_a = join_word(test_word_a_high, test_word_a_nibble); // [RULE_04]
  assign word_b = join_word(test_word_b_high,
    test_word_b_low[`TWRQ_NIB_MSB:`TWRQ_NIB_LSB]); // [RULE_01]

  // test pattern output
  always @(posedge aclk) begin
    if (!aresetn) begin
      test_data <= `TWRQ_RST_WORD;
      test_data_active <= 1'b0;
    end else begin
      case (output_test_select)
        `TWRQ_TSEL_WORD_A: begin
          test_data <= word_a; // [RULE_13]
          test_data_active <= 1'b1;
        end
        `TWRQ_TSEL_WORD_B: begin
          test_data <= word_b; // [RULE_13]
          test_data_active <= 1'b1;
        end
        default: begin
          test_data <= `TWRQ_RST_WORD;
          test_data_active <= 1'b0;
        end
      endcase
    end
  end

  // low bits pass to the unmonitored test pins as written
  always @(posedge aclk) begin
    if (!aresetn) begin
      unused_test_pins <= 4'h0;
    end else begin
      unused_test_pins <= test_word_b_low[`TWRQ_UNUSED_MSB:0];
    end
  end

  // post-processing enable, dual mode only
  always @(posedge aclk) begin
    if (!aresetn) begin
      dual_postproc_enable <= 1'b0;
    end else begin
      dual_postproc_enable <= dual_ch_mode
        & dual_postproc_ch_b_cfg[`TWRQ_POST_BIT]; // [RULE_10]
    end
  end

endmodule

// ### inc/twrq_consts.vh
// register indices, field positions, reset values and codes for twrq
`ifndef TWRQ_CONSTS_VH
`define TWRQ_CONSTS_VH

// bus widths
`define TWRQ_ADDR_W 12
`define TWRQ_DATA_W 32
`define TWRQ_IDX_W 10

// register indices, byte address is four times the index
`define TWRQ_IDX_A_HIGH 10'h075
`define TWRQ_IDX_B_LOW 10'h076
`define TWRQ_IDX_B_HIGH 10'h077
`define TWRQ_IDX_CLR_A 10'h078
`define TWRQ_IDX_POST_B 10'h079

// decoded register select codes
`define TWRQ_SEL_NONE 3'h0
`define TWRQ_SEL_A_HIGH 3'h1
`define TWRQ_SEL_B_LOW 3'h2
`define TWRQ_SEL_B_HIGH 3'h3
`define TWRQ_SEL_CLR_A 3'h4
`define TWRQ_SEL_POST_B 3'h5

// reset values
`define TWRQ_RST_BYTE 8'h00
`define TWRQ_RST_SET 7'h00
`define TWRQ_RST_WORD 12'h000

// field positions
`define TWRQ_CLR_BIT 7
`define TWRQ_POST_BIT 7
`define TWRQ_SET_MSB 6
`define TWRQ_NIB_MSB 7
`define TWRQ_NIB_LSB 4
`define TWRQ_UNUSED_MSB 3

// output test selector codes for the two user words
`define TWRQ_TSEL_WORD_A 3'h6
`define TWRQ_TSEL_WORD_B 3'h7

// bus responses
`define TWRQ_RESP_OKAY 2'h0
`define TWRQ_RESP_SLVERR 2'h2

`endif

// ### hw/twrq_axil.v
// axi4-lite slave front end for the twrq register slice
`timescale 1ns/10ps
`include "twrq_consts.vh"

module twrq_axil (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // write address channel
  input wire [`TWRQ_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // write data channel
  input wire [`TWRQ_DATA_W-1:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // write response channel
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // read address channel
  input wire [`TWRQ_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // read data channel
  output reg [`TWRQ_DATA_W-1:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // register file side
  output wire wr_fire,
  output wire [`TWRQ_IDX_W-1:0] wr_idx,
  output wire [7:0] wr_byte,
  output wire wr_lane0,
  input wire wr_hit,
  output wire [`TWRQ_IDX_W-1:0] rd_idx,
  input wire [7:0] rd_byte,
  input wire rd_hit
);

  reg aw_held;
  reg w_held;
  reg [`TWRQ_ADDR_W-1:0] aw_addr;
  reg [7:0] w_byte;
  reg w_lane0;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  assign wr_idx = aw_addr[`TWRQ_ADDR_W-1:2];
  assign wr_byte = w_byte;
  assign wr_lane0 = w_lane0;
  assign rd_idx = s_axi_araddr[`TWRQ_ADDR_W-1:2];

  // write path: address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {`TWRQ_ADDR_W{1'b0}};
      w_byte <= `TWRQ_RST_BYTE;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TWRQ_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `TWRQ_RESP_OKAY : `TWRQ_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read path: data one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= {`TWRQ_DATA_W{1'b0}};
      s_axi_rresp <= `TWRQ_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_hit ? `TWRQ_RESP_OKAY : `TWRQ_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ### test/twrq_regs_props.sv
// port assertions for twrq_regs
`timescale 1ns/10ps
module twrq_regs_props (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // inputs
  input wire s_axi_arvalid,
  input wire single_ch_mode,
  input wire dual_ch_mode,
  input wire [2:0] output_test_select,
  // outputs
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [11:0] test_data,
  input wire test_data_active,
  input wire [6:0] requant_ch_a_setting,
  input wire [6:0] requant_ch_b_setting,
  input wire requant_state_clear_a,
  input wire dual_postproc_enable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_no_dual;
    !dual_ch_mode && !$past(dual_ch_mode);
  endsequence
  property p_rd_ans;
    s_ar_taken |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_clr_one;
    requant_state_clear_a |=> !requant_state_clear_a;
  endproperty
  a_clr_one: assert property (p_clr_one) else $error("clear pulse too long");
  property p_set_clr;
    $changed(requant_ch_a_setting) |-> requant_state_clear_a;
  endproperty
  a_set_clr: assert property (p_set_clr) else $error("setting change without clear");
  property p_a_gate;
    !single_ch_mode && !$past(single_ch_mode) ##0 s_no_dual |-> requant_ch_a_setting == 7'h00;
  endproperty
  a_a_gate: assert property (p_a_gate) else $error("setting a applied off mode");
  property p_b_gate;
    s_no_dual |-> requant_ch_b_setting == 7'h00;
  endproperty
  a_b_gate: assert property (p_b_gate) else $error("setting b applied off mode");
  property p_post;
    s_no_dual |-> !dual_postproc_enable;
  endproperty
  a_post: assert property (p_post) else $error("post enable off mode");
  property p_idle;
    !test_data_active |-> test_data == 12'h000;
  endproperty
  a_idle: assert property (p_idle) else $error("test data while idle");
  property p_sel;
    test_data_active |-> $past(output_test_select) inside {3'h6, 3'h7};
  endproperty
  a_sel: assert property (p_sel) else $error("test data unselected");
endmodule
bind twrq_regs twrq_regs_props u_props (.*);

// ### test/twrq_regs_tb.sv
// self-checking bench for twrq_regs
`timescale 1ns/10ps
`include "twrq_consts.vh"
module twrq_regs_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic single_ch_mode, dual_ch_mode;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb, test_word_a_nibble;
  logic [2:0] output_test_select;
  logic [7:0] mdl [117:121];
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire test_data_active, requant_state_clear_a, requant_state_clear_b, dual_postproc_enable;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [11:0] test_data;
  wire [3:0] unused_test_pins;
  wire [6:0] requant_ch_a_setting, requant_ch_b_setting;
  int mismatches, compares, seed, ca, cb;

  twrq_regs DUT (.*);

  initial begin
    aclk = 0;
    forever #20 aclk = ~aclk;
  end

  // clear pulse counters
  always @(negedge aclk) begin
    ca += requant_state_clear_a === 1'b1;
    cb += requant_state_clear_b === 1'b1;
  end

  function automatic bit mapped(int i);
    return i > 116 && i < 122;
  endfunction

  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one bus access, write when w is set
  task automatic xfer(bit w, int i, logic [7:0] d, logic [3:0] s);
    logic ta, tw, done;
    logic [1:0] r;
    logic [31:0] q;
    done = 0;
    @(posedge aclk);
    s_axi_awaddr <= 12'(i * 4);
    s_axi_araddr <= 12'(i * 4);
    s_axi_wdata <= $random(seed) & 32'hFFFFFF00 | d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready | s_axi_arvalid & s_axi_arready;
      tw = s_axi_wvalid & s_axi_wready;
      done = w ? s_axi_bvalid : s_axi_rvalid;
      r = w ? s_axi_bresp : s_axi_rresp;
      q = s_axi_rdata;
      @(posedge aclk);
      if (ta) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
      if (tw) s_axi_wvalid <= 0;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    chk("done", done, 1'b1);
    chk("resp", r, mapped(i) ? `TWRQ_RESP_OKAY : `TWRQ_RESP_SLVERR);
    if (w && mapped(i) && s[0]) mdl[i] = d;
    if (!w) chk("rdata", q, mapped(i) ? mdl[i] : 0);
  endtask

  // test words and applied controls
  task automatic outs;
    logic [11:0] e;
    test_word_a_nibble <= 4'($random(seed));
    for (int s = 0; s < 8; s++) begin
      @(posedge aclk);
      output_test_select <= 3'(s);
      repeat (2) @(negedge aclk);
      e = s == 6 ? {mdl[117], test_word_a_nibble} : s == 7 ? {mdl[119], mdl[118][7:4]} : 12'h000;
      chk("test_data", test_data, e);
      chk("active", test_data_active, s > 5);
    end
    chk("unused", unused_test_pins, mdl[118][3:0]);
    e = single_ch_mode | dual_ch_mode ? mdl[120][6:0] : 12'h000;
    chk("set_a", requant_ch_a_setting, e);
    chk("set_b", requant_ch_b_setting, dual_ch_mode ? mdl[121][6:0] : 7'h00);
    chk("post", dual_postproc_enable, mdl[121][7] & dual_ch_mode);
  endtask

  initial begin
    seed = 91400;
    aresetn = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {single_ch_mode, dual_ch_mode, output_test_select, test_word_a_nibble} = 9'h000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    repeat (20) @(posedge aclk);
    // pass 0 and 7 check reset values, 7 after a second reset
    for (int p = 0; p < 8; p++) begin
      @(posedge aclk);
      aresetn <= p != 7;
      single_ch_mode <= p % 3 == 1;
      dual_ch_mode <= p % 3 == 2;
      @(posedge aclk);
      aresetn <= 1;
      if (p % 7 == 0)
        foreach (mdl[i]) mdl[i] = 8'h00;
      for (int i = 116; i < 123 && p % 7; i++)
        xfer(1, i, 8'($random(seed)) & (i == 118 ? 8'hF0 : 8'hFF), 4'($random(seed)));
      for (int i = 116; i < 123; i++)
        xfer(0, i, 8'h00, 4'h0);
      outs;
    end
    @(posedge aclk);
    dual_ch_mode <= 1;
    single_ch_mode <= 0;
    // toggle clear bit, rewrite same value, change setting a
    for (int k = 0; k < 3; k++) begin
      int a0, b0;
      repeat (4) @(posedge aclk);
      a0 = ca;
      b0 = cb;
      xfer(1, 120, mdl[120] ^ (k == 0 ? 8'h80 : k == 1 ? 8'h00 : 8'h01), 4'h1);
      repeat (4) @(posedge aclk);
      chk("clear_a", ca - a0, k != 1);
      chk("clear_b", cb - b0, k == 0);
    end
    give_verdict;
  end

  initial begin
    repeat (5000) @(posedge aclk);
    mismatches++;
    give_verdict;
  end
endmodule
